// [core/rhf_top.sv]
// Purpose: per-link header filter: interval lookup, invalid drop, output strip
// Assumes: token stream and configuration come from logic on clk
// Notes: header bytes are held, the route is decided, then the header is replayed
`timescale 1ns/1ns
module rhf_top (
   // clock and reset
   input  wire logic                                     clk,
   input  wire logic                                     srst,
   // input token stream
   input  wire logic                                     in_valid,
   input  wire logic [rhf_pkg::TOK_W-1:0]                in_data,
   input  wire logic                                     in_term,
   output logic                                          in_ready,
   // interval table
   input  wire logic [rhf_pkg::NUM_INT*rhf_pkg::HDR_W-1:0]  sep_flat,
   input  wire logic [rhf_pkg::NUM_INT*rhf_pkg::PORT_W-1:0] target_port_field,
   input  wire logic [rhf_pkg::NUM_INT-1:0]              invalid_flags,
   input  wire logic [rhf_pkg::NUM_INT-1:0]              discard_flags,
   // link configuration
   input  wire logic                                     header_size_select,
   input  wire logic                                     output_strip_enable,
   input  wire logic                                     link_inactive,
   input  wire logic                                     drop_after_fault,
   // chosen route
   output logic [rhf_pkg::PORT_W-1:0]                    route_port,
   output logic                                          route_open,
   // output token stream
   output logic                                          out_valid,
   output logic [rhf_pkg::TOK_W-1:0]                     out_data,
   output logic                                          out_term,
   input  wire logic                                     out_ready,
   // error status
   output logic                                          invalid_hdr_sticky,
   output logic                                          null_pkt_sticky,
   input  wire logic                                     clr_invalid_hdr,
   input  wire logic                                     clr_null_pkt
);
   rhf_pkg::rhf_top_type cur_ff;
   rhf_pkg::rhf_top_type nxt_ff;
   rhf_tok_if            tok ();

   logic                          hdr_done;
   logic [rhf_pkg::HDR_W-1:0]     hval;
   logic [6:0]                    lk;
   logic [5:0]                    lk_idx;
   logic                          lk_hit;
   logic                          lk_bad;
   logic [rhf_pkg::PORT_W-1:0]    lk_port;
   logic                          inv_ev;

   // first matching interval; a miss counts as invalid
   function automatic logic [6:0] find_int(
      input logic [rhf_pkg::HDR_W-1:0]                    h,
      input logic [rhf_pkg::NUM_INT*rhf_pkg::HDR_W-1:0]   seps);
      logic [6:0]                res;
      logic [rhf_pkg::HDR_W-1:0] base;
      logic [rhf_pkg::HDR_W-1:0] lim;
      res  = 7'h00;
      base = rhf_pkg::BASE_ZERO;
      for (int i = 0; i < rhf_pkg::NUM_INT; i++) begin
         lim  = seps[i*rhf_pkg::HDR_W +: rhf_pkg::HDR_W];
         if (!res[6] && h >= base && h < lim) begin
            res = {1'b1, 6'(i)};
         end
         // each separator is the limit below and the base above; no negative select
         base = lim;
      end
      return res;
   endfunction : find_int

   // headers are decoded until one is not in a portal interval; later bytes are body
   assign hdr_done = (cur_ff.st == rhf_pkg::RHF_HDR) && in_valid && !in_term
                     && (header_size_select == rhf_pkg::HSZ_ONE || cur_ff.hcnt);
   assign hval     = (header_size_select == rhf_pkg::HSZ_TWO) ? {in_data, cur_ff.hb0}
                                                               : {8'h00, in_data};
   // route depends on header and table only, never on the arrival link
   assign lk       = find_int(hval, sep_flat);
   assign lk_hit   = lk[6];
   assign lk_idx   = lk[5:0];
   assign lk_bad   = !lk_hit || invalid_flags[lk_idx];
   assign lk_port  = target_port_field[lk_idx*rhf_pkg::PORT_W +: rhf_pkg::PORT_W];
   assign inv_ev   = hdr_done && lk_bad;

   assign tok.cfg_strip = output_strip_enable;
   assign tok.cfg_hsize = header_size_select;
   assign tok.cfg_sink  = link_inactive && drop_after_fault;

   always_comb begin
      nxt_ff    = cur_ff;
      in_ready  = 1'b0;
      tok.valid = 1'b0;
      tok.data  = in_data;
      tok.term  = in_term;
      case (cur_ff.st)
         rhf_pkg::RHF_HDR: begin
            in_ready = 1'b1;
            if (in_valid && !in_term) begin
               if (!cur_ff.hcnt) begin
                  nxt_ff.hb0 = in_data;
               end else begin
                  nxt_ff.hb1 = in_data;
               end
               nxt_ff.hcnt = !hdr_done;
            end
            // a terminator cuts a half-received header; next byte starts afresh
            if (in_valid && in_term) begin
               nxt_ff.hcnt = 1'b0;
            end
            if (hdr_done) begin
               if (lk_bad) begin
                  nxt_ff.st = rhf_pkg::RHF_DROP;
               end else if (!discard_flags[lk_idx]) begin
                  nxt_ff.port = lk_port;
                  nxt_ff.st   = rhf_pkg::RHF_SEND0;
               end
               // portal interval: header swallowed, next header decoded
            end
         end
         rhf_pkg::RHF_SEND0: begin
            tok.valid = 1'b1;
            tok.data  = cur_ff.hb0;
            tok.term  = 1'b0;
            if (tok.ready) begin
               nxt_ff.st = (header_size_select == rhf_pkg::HSZ_TWO) ? rhf_pkg::RHF_SEND1
                                                                    : rhf_pkg::RHF_FWD;
            end
         end
         rhf_pkg::RHF_SEND1: begin
            tok.valid = 1'b1;
            tok.data  = cur_ff.hb1;
            tok.term  = 1'b0;
            if (tok.ready) begin
               nxt_ff.st = rhf_pkg::RHF_FWD;
            end
         end
         rhf_pkg::RHF_FWD: begin
            tok.valid = in_valid;
            in_ready  = tok.ready;
            if (in_valid && tok.ready && in_term) begin
               nxt_ff.st = rhf_pkg::RHF_HDR;
            end
         end
         rhf_pkg::RHF_DROP: begin
            in_ready = 1'b1;
            if (in_valid && in_term) begin
               nxt_ff.st = rhf_pkg::RHF_HDR;
            end
         end
         default: begin
            nxt_ff.st = rhf_pkg::RHF_HDR;
         end
      endcase
      // a new event in the clear cycle still sets the flag
      if (clr_invalid_hdr) begin
         nxt_ff.inv_sticky = 1'b0;
      end
      if (inv_ev) begin
         nxt_ff.inv_sticky = 1'b1;
      end
      if (clr_null_pkt) begin
         nxt_ff.null_sticky = 1'b0;
      end
      if (tok.null_ev) begin
         nxt_ff.null_sticky = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff    <= '0;
         cur_ff.st <= rhf_pkg::RHF_HDR;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   rhf_strip u_strip (
      .clk       (clk),
      .srst      (srst),
      .tok       (tok),
      .out_valid (out_valid),
      .out_data  (out_data),
      .out_term  (out_term),
      .out_ready (out_ready)
   );

   assign route_port         = cur_ff.port;
   assign route_open         = (cur_ff.st != rhf_pkg::RHF_HDR) && (cur_ff.st != rhf_pkg::RHF_DROP);
   assign invalid_hdr_sticky = cur_ff.inv_sticky;
   assign null_pkt_sticky    = cur_ff.null_sticky;

   sequence fwd_end_s;
      cur_ff.st == rhf_pkg::RHF_FWD && in_valid && in_ready && in_term;
   endsequence

   inv_drop_a: assert property (@(posedge clk) disable iff (srst)
      inv_ev |=> cur_ff.st == rhf_pkg::RHF_DROP && invalid_hdr_sticky && !route_open)
      else $error("invalid header not dropped");
   inv_wins_a: assert property (@(posedge clk) disable iff (srst)
      hdr_done && lk_hit && invalid_flags[lk_idx] && discard_flags[lk_idx]
      |=> cur_ff.st == rhf_pkg::RHF_DROP)
      else $error("discard flag beat invalid flag");
   port_pick_a: assert property (@(posedge clk) disable iff (srst)
      hdr_done && !lk_bad && !discard_flags[lk_idx]
      |=> route_open && route_port == $past(lk_port))
      else $error("wrong target port chosen");
   one_byte_a: assert property (@(posedge clk) disable iff (srst)
      cur_ff.st == rhf_pkg::RHF_HDR && in_valid && !in_term && !cur_ff.hcnt
      && header_size_select == rhf_pkg::HSZ_TWO |=> cur_ff.hcnt && !route_open)
      else $error("two-byte header decided early");
   path_hold_a: assert property (@(posedge clk) disable iff (srst)
      cur_ff.st == rhf_pkg::RHF_FWD && !(in_valid && in_ready && in_term)
      |=> cur_ff.st == rhf_pkg::RHF_FWD && $stable(route_port))
      else $error("path closed before terminator");
   path_close_a: assert property (@(posedge clk) disable iff (srst)
      fwd_end_s |=> !route_open)
      else $error("path not closed on terminator");
   sticky_set_a: assert property (@(posedge clk) disable iff (srst)
      tok.null_ev |=> null_pkt_sticky)
      else $error("null event lost against clear");
endmodule : rhf_top

// [inc/rhf_pkg.sv]
// Purpose: shared constants and types for the router header filter and strip block
// Assumes: one core clock, synchronous active-high reset
// Notes:
package rhf_pkg;
   localparam int          HDR_W     = 16;
   localparam int          TOK_W     = 8;
   localparam int          NUM_INT   = 36;
   localparam int          PORT_W    = 5;
   localparam logic        HSZ_ONE   = 1'b0;
   localparam logic        HSZ_TWO   = 1'b1;
   localparam logic [1:0]  STRIP_ONE = 2'h1;
   localparam logic [1:0]  STRIP_TWO = 2'h2;
   localparam logic [15:0] BASE_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      RHF_HDR,
      RHF_SEND0,
      RHF_SEND1,
      RHF_FWD,
      RHF_DROP
   } rhf_st_type;

   typedef struct packed {
      rhf_st_type         st;
      logic               hcnt;
      logic [TOK_W-1:0]   hb0;
      logic [TOK_W-1:0]   hb1;
      logic [PORT_W-1:0]  port;
      logic               inv_sticky;
      logic               null_sticky;
   } rhf_top_type;

   typedef struct packed {
      logic [1:0]        cnt;
      logic              seen;
      logic              ov;
      logic [TOK_W-1:0]  od;
      logic              ot;
      logic              null_ev;
   } rhf_strip_type;
endpackage : rhf_pkg

// [inc/rhf_tok_if.sv]
// Purpose: token stream from the routing stage to the output strip stage
// Assumes: same clock on both sides
// Notes: term marks a terminator token; data bit 0 then tells end-of-message
`timescale 1ns/1ns
interface rhf_tok_if;
   logic                      valid;
   logic                      ready;
   logic [rhf_pkg::TOK_W-1:0] data;
   logic                      term;
   logic                      cfg_strip;
   logic                      cfg_hsize;
   logic                      cfg_sink;
   logic                      null_ev;
   modport src (output valid, input ready, output data, output term,
                output cfg_strip, output cfg_hsize, output cfg_sink, input null_ev);
   modport snk (input valid, output ready, input data, input term,
                input cfg_strip, input cfg_hsize, input cfg_sink, output null_ev);
endinterface : rhf_tok_if

// [core/rhf_strip.sv]
// Purpose: output-side header strip with null packet detection
// Assumes: every packet reaching here starts with its full routing header
// Notes: one output register stage; sink mode swallows the packet but still flags null
`timescale 1ns/1ns
module rhf_strip (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // token stream in
   rhf_tok_if.snk                         tok,
   // token stream out
   output logic                           out_valid,
   output logic [rhf_pkg::TOK_W-1:0]      out_data,
   output logic                           out_term,
   input  wire logic                      out_ready
);
   rhf_pkg::rhf_strip_type cur_ff;
   rhf_pkg::rhf_strip_type nxt_ff;
   logic                   fire;
   logic [1:0]             nhdr;
   logic                   in_hdr;

   assign tok.ready = !cur_ff.ov || out_ready;
   assign fire      = tok.valid && tok.ready;
   assign nhdr      = (tok.cfg_hsize == rhf_pkg::HSZ_TWO) ? rhf_pkg::STRIP_TWO
                                                           : rhf_pkg::STRIP_ONE;
   assign in_hdr    = tok.cfg_strip && (cur_ff.cnt < nhdr);

   always_comb begin
      nxt_ff         = cur_ff;
      nxt_ff.null_ev = 1'b0;
      if (cur_ff.ov && out_ready) begin
         nxt_ff.ov = 1'b0;
      end
      if (fire) begin
         if (!tok.term) begin
            if (in_hdr) begin
               nxt_ff.cnt = cur_ff.cnt + 2'h1;
            end else begin
               nxt_ff.seen = 1'b1;
               if (!tok.cfg_sink) begin
                  nxt_ff.ov = 1'b1;
                  nxt_ff.od = tok.data;
                  nxt_ff.ot = 1'b0;
               end
            end
         end else begin
            // empty after strip: terminator goes too, even in sink mode
            nxt_ff.null_ev = tok.cfg_strip && !cur_ff.seen;
            nxt_ff.cnt     = 2'h0;
            nxt_ff.seen    = 1'b0;
            if (!tok.cfg_sink && !(tok.cfg_strip && !cur_ff.seen)) begin
               nxt_ff.ov = 1'b1;
               nxt_ff.od = tok.data;
               nxt_ff.ot = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign out_valid   = cur_ff.ov;
   assign out_data    = cur_ff.od;
   assign out_term    = cur_ff.ot;
   assign tok.null_ev = cur_ff.null_ev;

   sequence empty_end_s;
      fire && tok.term && tok.cfg_strip && !cur_ff.seen;
   endsequence

   body_pass_a: assert property (@(posedge clk) disable iff (srst)
      fire && !tok.term && !tok.cfg_sink && !in_hdr
      |=> out_valid && !out_term && out_data == $past(tok.data))
      else $error("body byte not forwarded");
   two_strip_a: assert property (@(posedge clk) disable iff (srst)
      fire && !tok.term && tok.cfg_strip && tok.cfg_hsize == rhf_pkg::HSZ_TWO
      && cur_ff.cnt == 2'h1 |=> cur_ff.cnt == 2'h2 && !(out_valid && !$past(out_valid)))
      else $error("second header byte not stripped");
   null_flag_a: assert property (@(posedge clk) disable iff (srst)
      empty_end_s |=> tok.null_ev && !(out_valid && out_term && !$past(out_valid)))
      else $error("null packet not flagged or terminator sent");
   null_sink_a: assert property (@(posedge clk) disable iff (srst)
      empty_end_s ##0 tok.cfg_sink |=> tok.null_ev ##1 !tok.null_ev)
      else $error("null packet lost in sink mode");
endmodule : rhf_strip

// [tb/rhf_sink_model.sv]
// Purpose: downstream link partner that accepts output tokens
// Assumes: same clock as the block
// Notes: slow mode takes one token in four to stall the strip stage
`timescale 1ns/1ns
module rhf_sink_model (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // stream from the block
   input  wire logic                      out_valid,
   input  wire logic [rhf_pkg::TOK_W-1:0] out_data,
   input  wire logic                      out_term,
   output logic                           out_ready,
   // stall control
   input  wire logic                      slow
);
   logic [rhf_pkg::TOK_W:0] rx_q[$];
   logic [1:0]              ph_ff;

   // token taken only on the edge where ready was high
   always @(posedge clk) begin
      if (srst) begin
         ph_ff <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         ph_ff <= ph_ff + 2'h1;
         out_ready <= !slow || (ph_ff == 2'h2);
         if (out_valid && out_ready) begin
            rx_q.push_back({out_term, out_data});
         end
      end
   end
endmodule : rhf_sink_model

// [tb/rhf_top_bench.sv]
// Purpose: self-checking bench for the header filter and strip block
// Assumes: static configuration between packets
// Notes: interval 1 invalid, interval 0 to port 3, the rest to port 7
`timescale 1ns/1ns
module rhf_top_bench;
   logic                                        clk, srst, in_valid, in_term, in_ready;
   logic [rhf_pkg::TOK_W-1:0]                   in_data, out_data;
   logic [rhf_pkg::NUM_INT*rhf_pkg::HDR_W-1:0]  sep_flat;
   logic [rhf_pkg::NUM_INT*rhf_pkg::PORT_W-1:0] tpf;
   logic [rhf_pkg::NUM_INT-1:0]                 inv_f, dis_f;
   logic                                        hsz, strip, inact, daf, clr_inv, clr_null;
   logic [rhf_pkg::PORT_W-1:0]                  route_port, seen_port;
   logic                                        route_open, out_valid, out_term, out_ready;
   logic                                        inv_st, null_st, slow;
   logic [rhf_pkg::TOK_W:0]                     pkt_q[$], exp_q[$];
   int                                          err_total, cmp_count;

   rhf_top dut_u (.clk(clk), .srst(srst), .in_valid(in_valid), .in_data(in_data),
      .in_term(in_term), .in_ready(in_ready), .sep_flat(sep_flat), .target_port_field(tpf),
      .invalid_flags(inv_f), .discard_flags(dis_f), .header_size_select(hsz),
      .output_strip_enable(strip), .link_inactive(inact), .drop_after_fault(daf),
      .route_port(route_port), .route_open(route_open), .out_valid(out_valid),
      .out_data(out_data), .out_term(out_term), .out_ready(out_ready),
      .invalid_hdr_sticky(inv_st), .null_pkt_sticky(null_st), .clr_invalid_hdr(clr_inv),
      .clr_null_pkt(clr_null));
   rhf_sink_model sink_u (.clk(clk), .srst(srst), .out_valid(out_valid), .out_data(out_data),
      .out_term(out_term), .out_ready(out_ready), .slow(slow));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task chk_flag(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_flag
   task chk_port(input string nm, input logic [4:0] e, input logic [4:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_port
   task chk_tok(input string nm, input logic [8:0] e, input logic [8:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_tok
   task chk_cnt(input string nm, input int e, input int g);
      cmp_count++;
      if (g != e) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt

   // upper separators collapse onto top, leaving null intervals above interval 2
   task set_table(input logic [15:0] top);
      for (int i = 0; i < rhf_pkg::NUM_INT; i++) begin
         sep_flat[16*i +: 16] <= (i == 0) ? 16'h0010 : (i == 1) ? 16'h0020 : top;
         tpf[5*i +: 5] <= (i == 0) ? 5'h03 : 5'h07;
      end
   endtask : set_table

   // valid held across the packet; bounded wait per token
   task send_pkt;
      int n;
      seen_port = 5'h1f;
      foreach (pkt_q[k]) begin
         in_valid <= 1'b1;
         in_data <= pkt_q[k][7:0];
         in_term <= pkt_q[k][8];
         n = 0;
         do begin
            @(posedge clk);
            n++;
            if (route_open === 1'b1) seen_port = route_port;
         end while (in_ready !== 1'b1 && n < 200);
         if (in_ready !== 1'b1) chk_flag("in ready", 1'b1, in_ready);
      end
      in_valid <= 1'b0;
      repeat (14) @(posedge clk);
   endtask : send_pkt

   task check_out;
      chk_cnt("out count", exp_q.size(), sink_u.rx_q.size());
      foreach (exp_q[k]) begin
         if (k < sink_u.rx_q.size()) begin
            chk_tok("out token", exp_q[k], sink_u.rx_q[k]);
         end
      end
      chk_flag("route open", 1'b0, route_open);
      sink_u.rx_q.delete();
   endtask : check_out

   task clear_flags;
      clr_inv <= 1'b1;
      clr_null <= 1'b1;
      @(posedge clk);
      clr_inv <= 1'b0;
      clr_null <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : clear_flags

   task end_test(input string nm);
      $display("test %s done", nm);
   endtask : end_test

   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test();
   end

   initial begin
      {in_valid, in_data, in_term, sep_flat, tpf, hsz, strip, inact, daf} = '0;
      {clr_inv, clr_null, slow, err_total, cmp_count} = '0;
      inv_f = 36'h2;
      dis_f = 36'h2;
      srst = 1'b1;
      set_table(16'h00ff);
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk_flag("invalid sticky", 1'b0, inv_st);
      chk_flag("null sticky", 1'b0, null_st);
      // sub-header 0x15 sits in the invalid range but is body
      pkt_q = {9'h005, 9'h015, 9'h101};
      exp_q = pkt_q;
      send_pkt();
      check_out();
      chk_port("route port", 5'h03, seen_port);
      chk_flag("invalid sticky", 1'b0, inv_st);
      end_test("route");
      pkt_q = {9'h018, 9'h0aa, 9'h100};
      exp_q = {};
      send_pkt();
      check_out();
      chk_flag("invalid sticky", 1'b1, inv_st);
      clear_flags();
      chk_flag("invalid sticky", 1'b0, inv_st);
      end_test("invalid");
      strip <= 1'b1;
      slow <= 1'b1;
      @(posedge clk);
      pkt_q = {9'h025, 9'h0aa, 9'h0bb, 9'h100};
      exp_q = {9'h0aa, 9'h0bb, 9'h100};
      send_pkt();
      check_out();
      chk_port("route port", 5'h07, seen_port);
      chk_flag("null sticky", 1'b0, null_st);
      end_test("strip one");
      hsz <= 1'b1;
      slow <= 1'b0;
      set_table(16'hffff);
      @(posedge clk);
      // header cut by a terminator must not leave its first byte behind
      pkt_q = {9'h020, 9'h100};
      exp_q = {};
      send_pkt();
      check_out();
      pkt_q = {9'h000, 9'h001, 9'h011, 9'h101};
      exp_q = {9'h011, 9'h101};
      send_pkt();
      check_out();
      chk_port("route port", 5'h07, seen_port);
      // low byte first gives 0x0015, inside the invalid interval
      pkt_q = {9'h015, 9'h000, 9'h0cc, 9'h100};
      exp_q = {};
      send_pkt();
      check_out();
      chk_flag("invalid sticky", 1'b1, inv_st);
      clear_flags();
      end_test("strip two");
      hsz <= 1'b0;
      set_table(16'h00ff);
      @(posedge clk);
      pkt_q = {9'h025, 9'h101};
      exp_q = {};
      send_pkt();
      check_out();
      chk_flag("null sticky", 1'b1, null_st);
      clear_flags();
      chk_flag("null sticky", 1'b0, null_st);
      end_test("null");
      inact <= 1'b1;
      daf <= 1'b1;
      @(posedge clk);
      pkt_q = {9'h025, 9'h0aa, 9'h100};
      exp_q = {};
      send_pkt();
      check_out();
      chk_flag("null sticky", 1'b0, null_st);
      pkt_q = {9'h025, 9'h101};
      send_pkt();
      check_out();
      chk_flag("null sticky", 1'b1, null_st);
      end_test("sink");
      finish_test();
   end
endmodule : rhf_top_bench
